// ---- include/timer_pkg.sv ----
// Purpose: Shared constants for the basic up-counting timer with update control.
// Assumes: 32-bit classic Wishbone register bus, one 100 MHz clock.
// Notes: Register offsets are byte addresses; each register takes one aligned word.
package timer_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_TRIGGER   = 8'h14;
    localparam logic [7:0] OFS_COUNT     = 8'h24;
    localparam logic [7:0] OFS_DIVISOR   = 8'h28;
    localparam logic [7:0] OFS_RELOAD    = 8'h2c;

    // Control field positions.
    localparam int BIT_RUN_ENABLE    = 0;
    localparam int BIT_EVENT_DISABLE = 1;
    localparam int BIT_REQ_SOURCE    = 2;
    localparam int BIT_SINGLE_SHOT   = 3;
    localparam int BIT_RELOAD_BUFFER = 7;

    // Status, mask and trigger field position.
    localparam int BIT_UPDATE_FLAG   = 0;
    localparam int BIT_SOFT_REQUEST  = 0;

    // Values after reset.
    localparam logic [15:0] RST_CONTROL  = 16'h0000;
    localparam logic [15:0] RST_DIVISOR  = 16'h0000;
    localparam logic [15:0] RST_RELOAD   = 16'hffff;
    localparam logic [15:0] RST_COUNT    = 16'h0000;

    // Writable bits of the control register.
    localparam logic [15:0] CONTROL_MASK = 16'h008f;

    // Bus answer latency in cycles after the request is seen.
    localparam int BUS_ACK_CYCLES = 1;

endpackage

// ---- logic/prescale_divider.sv ----
// Purpose: Prescaler counter that turns the timer clock into a counter clock enable.
// Assumes: divisor is the active shadow value, held stable between update events.
// Notes: tick is a one-cycle pulse every divisor plus one enabled cycles.
`timescale 1ns/100ps
module prescale_divider #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);
    import timer_pkg::*;

    logic [WIDTH-1:0] phase;
    logic [WIDTH-1:0] next_phase;

    // Count enabled cycles and fire once the phase reaches the divisor.
    always_comb begin
        next_phase = phase;
        tick       = 1'b0;
        if (restart) begin
            next_phase = '0;
        end else if (run) begin
            if (phase >= divisor) begin
                next_phase = '0;
                tick       = 1'b1;
            end else begin
                next_phase = phase + 1'b1;
            end
        end
    end

    // Register the prescaler phase.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase <= '0;
        end else begin
            phase <= next_phase;
        end
    end

endmodule

// ---- logic/basic_timer.sv ----
// Purpose: Sixteen-bit up-counting timer with update event, one-shot and reload buffering.
// Assumes: Classic Wishbone slave, 32-bit data, byte address on adr, single clock sys_clk.
// Notes: Control, count, divisor and reload are sixteen bits in the low lanes; mask and status use bit 0 only; upper bits read as zero.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module basic_timer #(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [7:0]  adr,
    input  wire logic [3:0]  sel,
    input  wire logic [31:0] dat_w,
    output logic      [31:0] dat_r,
    output logic             ack,
    output logic             irq,
    output logic             refresh_event,
    output logic             counter_running
);
    import timer_pkg::*;

    // Merge the two low byte lanes of a write into a sixteen-bit register.
    function automatic logic [15:0] lane_merge(input logic [15:0] old_value,
                                               input logic [31:0] data,
                                               input logic [3:0]  lanes);
        logic [15:0] merged;
        merged = old_value;
        if (lanes[0]) begin
            merged[7:0] = data[7:0];
        end
        if (lanes[1]) begin
            merged[15:8] = data[15:8];
        end
        return merged;
    endfunction

    // Register state.
    logic [15:0]          timer_control_one;
    logic [15:0]          prescale_divisor;
    logic [15:0]          reload_limit;
    logic                 irq_mask;
    logic                 update_flag;
    logic                 soft_refresh_request;

    // Active shadows and counter.
    logic [15:0]          divisor_value;
    logic [CNT_WIDTH-1:0] reload_value;
    logic [CNT_WIDTH-1:0] count;

    // Next values.
    logic [15:0]          next_timer_control_one;
    logic [15:0]          next_prescale_divisor;
    logic [15:0]          next_reload_limit;
    logic                 next_irq_mask;
    logic                 next_update_flag;
    logic                 next_soft_refresh_request;
    logic [15:0]          next_divisor_value;
    logic [CNT_WIDTH-1:0] next_reload_value;
    logic [CNT_WIDTH-1:0] next_count;
    logic [31:0]          next_dat_r;
    logic                 next_ack;

    // Decoded control fields.
    logic                 count_run_enable;
    logic                 refresh_event_disable;
    logic                 refresh_request_source;
    logic                 single_shot_select;
    logic                 reload_buffer_enable;

    // Internal event terms.
    logic                 bus_take;
    logic                 bus_write;
    logic                 bus_read;
    logic                 count_tick;
    logic                 overflow;
    logic [CNT_WIDTH-1:0] limit_now;
    logic                 update_request;

    // Control fields are plain bits of the control register.
    assign count_run_enable       = timer_control_one[BIT_RUN_ENABLE];
    assign refresh_event_disable  = timer_control_one[BIT_EVENT_DISABLE];
    assign refresh_request_source = timer_control_one[BIT_REQ_SOURCE];
    assign single_shot_select     = timer_control_one[BIT_SINGLE_SHOT];
    assign reload_buffer_enable   = timer_control_one[BIT_RELOAD_BUFFER];
    assign counter_running        = count_run_enable;

    // A request is taken once; ack drops the cycle after it is given.
    assign bus_take  = cyc && stb && !ack;
    assign bus_write = bus_take && we;
    assign bus_read  = bus_take && !we;

    // Without buffering the written reload value is used at once.
    assign limit_now = reload_buffer_enable ? reload_value
                                            : reload_limit[CNT_WIDTH-1:0];

    // The prescaler only runs while enabled and a non-zero reload is active.
    prescale_divider #(
        .WIDTH (16)
    ) prescale_divider_inst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (count_run_enable && (limit_now != '0)),
        .restart (soft_refresh_request),
        .divisor (divisor_value),
        .tick    (count_tick)
    );

    // Overflow is the wrap from the reload value back to zero.
    assign overflow = count_tick && (count >= limit_now);

    // Update event from overflow or software request, unless disabled.
    assign refresh_event = !refresh_event_disable
                           && (overflow || soft_refresh_request);

    // Flag source: software requests only count when the source bit is clear.
    assign update_request = refresh_event
                            && (overflow || !refresh_request_source);

    // One interrupt level, high while an unmasked flag is set.
    assign irq = update_flag && irq_mask;

    // Next state of counter, shadows, control and status.
    always_comb begin
        next_timer_control_one    = timer_control_one;
        next_prescale_divisor     = prescale_divisor;
        next_reload_limit         = reload_limit;
        next_irq_mask             = irq_mask;
        next_update_flag          = update_flag;
        next_soft_refresh_request = 1'b0;
        next_divisor_value        = divisor_value;
        next_reload_value         = reload_value;
        next_count                = count;

        // Software writes land at the acknowledging edge.
        if (bus_write) begin
            case (adr)
                OFS_CONTROL: begin
                    next_timer_control_one = lane_merge(timer_control_one, dat_w, sel)
                                             & CONTROL_MASK;
                end
                OFS_IRQ_MASK: begin
                    if (sel[0]) begin
                        next_irq_mask = dat_w[BIT_UPDATE_FLAG];
                    end
                end
                OFS_TRIGGER: begin
                    if (sel[0]) begin
                        next_soft_refresh_request = dat_w[BIT_SOFT_REQUEST];
                    end
                end
                OFS_COUNT: begin
                    next_count = CNT_WIDTH'(lane_merge(16'(count), dat_w, sel));
                end
                OFS_DIVISOR: begin
                    next_prescale_divisor = lane_merge(prescale_divisor, dat_w, sel);
                end
                OFS_RELOAD: begin
                    next_reload_limit = lane_merge(reload_limit, dat_w, sel);
                end
                default: begin
                end
            endcase
        end

        // A status read clears the flag before any new event is applied.
        if (bus_read && adr == OFS_STATUS) begin
            next_update_flag = 1'b0;
        end

        // Counting: software request restarts, a tick advances or wraps.
        if (soft_refresh_request) begin
            next_count = '0;
        end else if (count_tick) begin
            if (overflow) begin
                next_count = '0;
            end else begin
                next_count = count + 1'b1;
            end
        end

        // Update event refreshes shadows and may stop a one-shot run.
        if (refresh_event) begin
            next_divisor_value = prescale_divisor;
            next_reload_value  = reload_limit[CNT_WIDTH-1:0];
            if (single_shot_select) begin
                next_timer_control_one[BIT_RUN_ENABLE] = 1'b0;
            end
        end

        // The flag set wins over a clear in the same cycle.
        if (update_request) begin
            next_update_flag = 1'b1;
        end
    end

    // Register counter, shadows, control and status.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_control_one    <= RST_CONTROL;
            prescale_divisor     <= RST_DIVISOR;
            reload_limit         <= RST_RELOAD;
            irq_mask             <= 1'b0;
            update_flag          <= 1'b0;
            soft_refresh_request <= 1'b0;
            divisor_value        <= RST_DIVISOR;
            reload_value         <= RST_RELOAD[CNT_WIDTH-1:0];
            count                <= RST_COUNT[CNT_WIDTH-1:0];
        end else begin
            timer_control_one    <= next_timer_control_one;
            prescale_divisor     <= next_prescale_divisor;
            reload_limit         <= next_reload_limit;
            irq_mask             <= next_irq_mask;
            update_flag          <= next_update_flag;
            soft_refresh_request <= next_soft_refresh_request;
            divisor_value        <= next_divisor_value;
            reload_value         <= next_reload_value;
            count                <= next_count;
        end
    end

    // Read data and acknowledge for the bus; unmapped offsets read zero.
    always_comb begin
        next_dat_r = 32'h0000_0000;
        next_ack   = bus_take;
        if (bus_read) begin
            case (adr)
                OFS_CONTROL: begin
                    next_dat_r = {16'h0000, timer_control_one};
                end
                OFS_IRQ_MASK: begin
                    next_dat_r[BIT_UPDATE_FLAG] = irq_mask;
                end
                OFS_STATUS: begin
                    next_dat_r[BIT_UPDATE_FLAG] = update_flag;
                end
                OFS_COUNT: begin
                    next_dat_r = {16'h0000, 16'(count)};
                end
                OFS_DIVISOR: begin
                    next_dat_r = {16'h0000, prescale_divisor};
                end
                OFS_RELOAD: begin
                    next_dat_r = {16'h0000, reload_limit};
                end
                default: begin
                    next_dat_r = 32'h0000_0000;
                end
            endcase
        end
    end

    // Register the bus answer.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dat_r <= 32'h0000_0000;
            ack   <= 1'b0;
        end else begin
            dat_r <= next_dat_r;
            ack   <= next_ack;
        end
    end

endmodule

// ---- bench/basic_timer_checker.sv ----
// Purpose: Port-level assertions for the basic timer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Helper bits mirror control and mask writes seen on the bus.
`timescale 1ns/100ps
module basic_timer_checker
    import timer_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cyc,
    input wire logic        stb,
    input wire logic        we,
    input wire logic [7:0]  adr,
    input wire logic [3:0]  sel,
    input wire logic [31:0] dat_w,
    input wire logic [31:0] dat_r,
    input wire logic        ack,
    input wire logic        irq,
    input wire logic        refresh_event,
    input wire logic        counter_running
);
    logic take, shot_q, dis_q, mask_q, next_shot, next_dis, next_mask;
    // A request is taken on an edge with strobe up and no answer pending.
    assign take = cyc && stb && !ack;
    // Next values of the mirrored control and mask bits.
    always_comb begin
        next_shot = shot_q;
        next_dis  = dis_q;
        next_mask = mask_q;
        if (take && we && adr == OFS_CONTROL && sel[0]) begin
            next_shot = dat_w[BIT_SINGLE_SHOT];
            next_dis  = dat_w[BIT_EVENT_DISABLE];
        end
        if (take && we && adr == OFS_IRQ_MASK && sel[0]) begin
            next_mask = dat_w[BIT_UPDATE_FLAG];
        end
    end
    // Registers the mirrored bits.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {shot_q, dis_q, mask_q} <= 3'b000;
        end else begin
            {shot_q, dis_q, mask_q} <= {next_shot, next_dis, next_mask};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_ctl_write; take && we && adr == OFS_CONTROL && sel[0]; endsequence
    sequence s_soft; take && we && adr == OFS_TRIGGER && sel[0] && dat_w[BIT_SOFT_REQUEST]; endsequence
    sequence s_stat_read; take && !we && adr == OFS_STATUS && !refresh_event; endsequence
    a_ack_one_pulse: assert property (take |=> ack ##1 !ack) else $error("ack not a single pulse");
    a_idle_data_zero: assert property (!ack |-> dat_r == 32'h0) else $error("read data not zero");
    a_run_follows_write: assert property (s_ctl_write |=>
        counter_running == $past(dat_w[BIT_RUN_ENABLE]) || $past(refresh_event && shot_q))
        else $error("run bit not written");
    a_run_rise_cause: assert property ($rose(counter_running) |-> $past(take && we && adr == OFS_CONTROL))
        else $error("run rose without write");
    a_single_shot_stop: assert property (refresh_event && shot_q |=> !counter_running)
        else $error("one-shot did not stop");
    a_disabled_silent: assert property (dis_q |-> !refresh_event) else $error("event while disabled");
    a_soft_event: assert property (s_soft ##1 !dis_q |-> ##[0:1] refresh_event)
        else $error("no event after soft request");
    a_status_read_clear: assert property (s_stat_read |=> !irq) else $error("irq after status read");
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(refresh_event) ||
        $past(take && we && adr == OFS_IRQ_MASK)) else $error("irq rose without cause");
    a_irq_needs_mask: assert property (irq |-> mask_q) else $error("irq while masked");
endmodule
bind basic_timer basic_timer_checker #(.CNT_WIDTH(CNT_WIDTH)) basic_timer_checker_inst (.sys_clk(sys_clk),
    .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r),
    .ack(ack), .irq(irq), .refresh_event(refresh_event), .counter_running(counter_running));

// ---- bench/basic_timer_tb.sv ----
// Purpose: Self-checking bench for the basic timer over Wishbone.
// Assumes: Bus answer in one cycle, event pulse one cycle wide.
// Notes: Periods are measured between event pulses.
`timescale 1ns/100ps
module basic_timer_tb;
    import timer_pkg::*;
    logic        sys_clk, rst, cyc, stb, we, ack, irq, refresh_event, counter_running;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, rd, top;
    int          n_mismatch, check_count, ev_count, gap, ev0, i;
    basic_timer #(.CNT_WIDTH(16)) basic_timer_inst (.sys_clk(sys_clk), .rst(rst), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .irq(irq),
        .refresh_event(refresh_event), .counter_running(counter_running));
    // Clock and event counting.
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (refresh_event === 1'b1) ev_count <= ev_count + 1;
    // Compares a value and records any mismatch.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; waits for ack under a bound.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {cyc, stb, we, adr, sel, dat_w} <= {1'b1, 1'b1, wr, a, 4'hf, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_r;
        {cyc, stb, we} <= 3'b000;
        if (n >= 50) check("ack", 32'h0, 32'h1);
    endtask
    // Counts cycles up to the next event pulse.
    task automatic measure();
        gap = 0;
        do begin
            @(posedge sys_clk);
            gap++;
        end while (refresh_event !== 1'b1 && gap < 1000);
        if (gap >= 1000) check("event wait", 32'h0, 32'h1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run.
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        {sys_clk, rst, cyc, stb, we, adr, sel, dat_w, ev_count} = {3'b010, 2'b00, 8'h0, 4'h0, 32'h0, 32'h0};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, OFS_CONTROL, 0); check("control", rd, {16'h0, RST_CONTROL});
        bus(0, OFS_DIVISOR, 0); check("divisor", rd, 32'h0);
        bus(0, OFS_RELOAD, 0); check("reload", rd, 32'hffff);
        bus(1, 8'h30, 32'h1234);
        bus(0, 8'h30, 0); check("unmapped", rd, 32'h0);
        // Soft request loads the divisor and raises the flag.
        bus(1, OFS_DIVISOR, 2);
        bus(1, OFS_RELOAD, 4);
        bus(1, OFS_IRQ_MASK, 1);
        bus(0, OFS_IRQ_MASK, 0); check("mask", rd, 1);
        ev0 = ev_count;
        bus(1, OFS_TRIGGER, 1);
        repeat (3) @(posedge sys_clk);
        check("soft events", ev_count - ev0, 1);
        check("irq", {31'h0, irq}, 1);
        bus(0, OFS_STATUS, 0); check("status", rd, 1);
        bus(0, OFS_STATUS, 0); check("status", rd, 0);
        check("irq", {31'h0, irq}, 0);
        // Period is (divisor+1)*(reload+1).
        bus(1, OFS_CONTROL, 1); check("running", {31'h0, counter_running}, 1);
        measure();
        measure(); check("period", gap, 15);
        // Buffered reload waits for the event.
        bus(1, OFS_CONTROL, 32'h81);
        measure();
        bus(1, OFS_RELOAD, 1);
        top = 0;
        for (i = 0; i < 6; i++) begin
            bus(0, OFS_COUNT, 0);
            if (rd > top) top = rd;
        end
        check("old limit", {31'h0, top > 32'h1}, 1);
        measure();
        measure(); check("period", gap, 6);
        // Unbuffered zero reload stops the counter at once.
        bus(1, OFS_CONTROL, 1);
        bus(1, OFS_RELOAD, 0);
        ev0 = ev_count;
        bus(0, OFS_COUNT, 0);
        top = rd;
        repeat (20) @(posedge sys_clk);
        bus(0, OFS_COUNT, 0); check("frozen", rd, top);
        check("no events", ev_count - ev0, 0);
        // A counter written while stopped keeps the written value.
        bus(1, OFS_COUNT, 32'h3);
        repeat (10) @(posedge sys_clk);
        bus(0, OFS_COUNT, 0); check("count write", rd, 32'h3);
        bus(1, OFS_RELOAD, 4);
        // Overflow-only source: the soft request gives an event but no flag.
        bus(1, OFS_CONTROL, 4);
        bus(0, OFS_STATUS, 0);
        ev0 = ev_count;
        bus(1, OFS_TRIGGER, 1);
        repeat (3) @(posedge sys_clk);
        check("soft events", ev_count - ev0, 1);
        bus(0, OFS_STATUS, 0); check("status", rd, 0);
        // Disabled events: overflow silent, soft request still restarts.
        bus(1, OFS_CONTROL, 3);
        ev0 = ev_count;
        repeat (40) @(posedge sys_clk);
        bus(1, OFS_CONTROL, 2);
        bus(1, OFS_TRIGGER, 1);
        bus(0, OFS_COUNT, 0); check("restart", rd, 0);
        check("no events", ev_count - ev0, 0);
        // One-shot stops at the event; masked flag keeps irq low.
        bus(1, OFS_IRQ_MASK, 0);
        bus(1, OFS_CONTROL, 9);
        measure();
        repeat (2) @(posedge sys_clk);
        check("running", {31'h0, counter_running}, 0);
        check("irq", {31'h0, irq}, 0);
        bus(0, OFS_CONTROL, 0); check("control", rd, 32'h8);
        bus(0, OFS_STATUS, 0); check("status", rd, 1);
        results();
    end
endmodule
